//--- fuc_cmd_core.sv
// Command core for password unlock, software reset, mode-bit reset, sleep and wake.
// Assumes SPI mode 0 or 3 pins at far below clk_sys; flag and default inputs are
// from logic on clk_sys.
//
// Behaviour
// - Unlock runs only if select rises right after the 64th password bit.
// - Pending flag stays high during unlock; status reads remain allowed.
// - Password mismatch sets failure flag and leaves pending flag stuck high.
// - Only flag clear, software reset or hardware reset clear mismatch flags.
// - Matching password sets the protection freeze bit.
// - Software reset reloads volatile registers from their non-volatile defaults.
// - Software reset keeps guard and freeze bits; only hard resets restore them.
// - Armed reset opcode executes on select rise, lasting the init time.
// - After an incomplete power-up, reset runs a full power-up sequence.
// - Any command after arming cancels the arm; reset is then ignored.
// - Eight clocks of ones on data line zero leave continuous read.
// - Sleep opcode needs select rise right after bit eight; entry is timed.
// - While asleep only the wake opcode is recognised, status reads too ignored.
// - Hardware reset works while asleep and restores normal operation.
// - Wake needs select high for the wake time; commands ignored meanwhile.
// - Wake opcode plus three dummy bytes returns the ID, MSb first, on falls.
// - Wake opcode is ignored while an erase, program or write is busy.
// - In quad mode commands, password and ID use all four data lines.
`timescale 1ns/1ns
`include "fuc_consts.svh"
module fuc_cmd_core
#(
	parameter logic [`FUC_TMR_W-1:0] POWER_UP_CYC = `FUC_TMR_W'(`FUC_CYC_UP(`FUC_POWER_UP_NS)),
	parameter logic [7:0] DEV_ID = `FUC_DEV_ID // Arbitrary value
)
(
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic hw_rst_n,
	// Configuration and defaults
	input wire logic quad_cmd_mode,
	input wire logic [63:0] hidden_password,
	input wire logic nv_freeze_default,
	input wire logic nv_cfg_guard,
	input wire logic cfg_guard_set,
	// Other device logic
	input wire logic cont_read_enter,
	input wire logic array_busy,
	input wire logic por_abort,
	// Status
	output logic op_pending_flag,
	output logic prog_fail_flag,
	output logic protection_freeze_bit,
	output logic cfg_guard_bit,
	output logic cont_read_mode,
	output logic sleep_mode,
	output logic vol_reload,
	output logic dev_ready
);

	localparam logic [`FUC_TMR_W-1:0] SW_INIT_CYC = `FUC_TMR_W'(`FUC_CYC_UP(`FUC_SW_INIT_NS));
	localparam logic [`FUC_TMR_W-1:0] ENTRY_CYC = `FUC_TMR_W'(`FUC_CYC_DN(`FUC_SLEEP_ENTRY_NS));
	localparam logic [`FUC_TMR_W-1:0] WAKE_CYC = `FUC_TMR_W'(`FUC_CYC_UP(`FUC_WAKE_NS));
	localparam logic [`FUC_TMR_W-1:0] UNLOCK_CYC = `FUC_TMR_W'(`FUC_CYC_UP(`FUC_UNLOCK_NS));
	localparam logic [7:0] OPC_END = 8'(`FUC_OPC_BITS);
	localparam logic [7:0] PASS_END = 8'(`FUC_OPC_BITS + `FUC_PW_BITS);
	localparam logic [7:0] DUMMY_END = 8'(`FUC_OPC_BITS + `FUC_DUMMY_BITS);
	localparam logic [3:0] EXIT_CLKS = 4'(`FUC_EXIT_CLKS);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] shift8(input logic [7:0] s, input logic [3:0] d,
		input logic q);
		shift8 = q ? {s[3:0], d} : {s[6:0], d[0]};
	endfunction

	function automatic logic [63:0] shift64(input logic [63:0] s, input logic [3:0] d,
		input logic q);
		shift64 = q ? {s[59:0], d} : {s[62:0], d[0]};
	endfunction

	function automatic logic [63:0] byte_swap(input logic [63:0] s);
		byte_swap = '0;
		for (int i = 0; i < 8; i++)
			byte_swap[8*i +: 8] = s[8*(7-i) +: 8];
	endfunction

	// ==========================================================
	// Submodules
	fuc_link_if lnk();

	fuc_link_sync u_sync
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cs_n(cs_n),
		.sck(sck),
		.io_in(io_in),
		.hw_rst_n(hw_rst_n),
		.lnk(lnk.src)
	);

	logic tmr_start;
	logic [`FUC_TMR_W-1:0] tmr_load;
	logic tmr_done;

	fuc_timer u_timer
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(tmr_start),
		.load(tmr_load),
		.busy(),
		.done(tmr_done)
	);

	// ==========================================================
	// Declarations
	fuc_pkg::fuc_frame_t fr;
	fuc_pkg::fuc_op_t op;
	logic hard_rst;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [7:0] opc;
	logic opc_seen;
	logic opc_ok;
	logic opc_allow;
	logic [63:0] pw;
	logic [3:0] exit_clks;
	logic exit_ones;
	logic [7:0] tx;
	logic [7:0] status;
	logic arm;
	logic req_init;
	logic req_unlock;
	logic req_sleep;
	logic req_wake;
	logic req_clear;
	logic req_exit;
	logic fail;
	logic por_ok;
	logic pw_match;
	logic unlock_hit;

	assign hard_rst = sys_rst | lnk.hw_rst;
	assign next_cnt = (cnt > 8'hf0) ? cnt : cnt + (quad_cmd_mode ? 8'h04 : 8'h01);
	assign next_sh = shift8(sh, lnk.io, quad_cmd_mode);
	assign pw_match = byte_swap(pw) == hidden_password;
	assign unlock_hit = (op == fuc_pkg::OP_UNLOCK) && tmr_done && pw_match;

	always_comb
	begin
		status = 8'h00;
		status[`FUC_STAT_PEND] = op_pending_flag;
		status[`FUC_STAT_FAIL] = fail;
	end

	// ==========================================================
	// Opcode acceptance by operation state
	always_comb
	begin
		unique case (op)
			fuc_pkg::OP_READY:
				opc_allow = !cont_read_mode && !(next_sh == `FUC_OPC_WAKE && array_busy);
			fuc_pkg::OP_UNLOCK:
				opc_allow = next_sh == `FUC_OPC_STAT_RD;
			fuc_pkg::OP_FAIL:
				opc_allow = next_sh == `FUC_OPC_STAT_RD || next_sh == `FUC_OPC_FLAG_CLR
					|| next_sh == `FUC_OPC_ARM || next_sh == `FUC_OPC_INIT;
			fuc_pkg::OP_SLEEP:
				opc_allow = next_sh == `FUC_OPC_WAKE && !array_busy;
			fuc_pkg::OP_POWERUP, fuc_pkg::OP_RESET, fuc_pkg::OP_DOZE, fuc_pkg::OP_WAKE:
				opc_allow = 1'b0;
		endcase
	end

	// ==========================================================
	// Serial frame receiver
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			fr <= fuc_pkg::FR_IDLE;
			cnt <= 8'h00;
			sh <= 8'h00;
			opc <= 8'h00;
			opc_seen <= 1'b0;
			opc_ok <= 1'b0;
			pw <= '0;
			exit_clks <= 4'h0;
			exit_ones <= 1'b0;
		end
		else if (lnk.cs_start)
		begin
			fr <= fuc_pkg::FR_OPCODE;
			cnt <= 8'h00;
			sh <= 8'h00;
			opc_seen <= 1'b0;
			opc_ok <= 1'b0;
			exit_clks <= 4'h0;
			exit_ones <= 1'b1;
		end
		else if (lnk.sck_rise)
		begin
			cnt <= next_cnt;
			if (exit_clks != EXIT_CLKS)
			begin
				exit_clks <= exit_clks + 4'h1;
				exit_ones <= exit_ones & lnk.io[0];
			end
			unique case (fr)
				fuc_pkg::FR_OPCODE:
				begin
					sh <= next_sh;
					if (next_cnt == OPC_END)
					begin
						opc <= next_sh;
						opc_seen <= 1'b1;
						opc_ok <= opc_allow;
						if (!opc_allow)
							fr <= fuc_pkg::FR_SKIP;
						else if (next_sh == `FUC_OPC_UNLOCK)
							fr <= fuc_pkg::FR_PASS;
						else if (next_sh == `FUC_OPC_WAKE)
							fr <= fuc_pkg::FR_DUMMY;
						else if (next_sh == `FUC_OPC_STAT_RD)
							fr <= fuc_pkg::FR_SEND;
						else
							fr <= fuc_pkg::FR_SKIP;
					end
				end
				fuc_pkg::FR_PASS:
					pw <= shift64(pw, lnk.io, quad_cmd_mode);
				fuc_pkg::FR_DUMMY:
					if (next_cnt == DUMMY_END)
						fr <= fuc_pkg::FR_SEND;
				fuc_pkg::FR_IDLE, fuc_pkg::FR_SEND, fuc_pkg::FR_SKIP:
					fr <= fr;
			endcase
		end
		else if (lnk.cs_end)
			fr <= fuc_pkg::FR_IDLE;
	end

	// ==========================================================
	// Output shifter: ID or status out on falling serial clock edges
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			tx <= 8'h00;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
		else if (!lnk.cs_active)
		begin
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
		else if (lnk.sck_rise && fr == fuc_pkg::FR_OPCODE && next_cnt == OPC_END)
			tx <= status;
		else if (lnk.sck_rise && fr == fuc_pkg::FR_DUMMY && next_cnt == DUMMY_END)
			tx <= DEV_ID;
		else if (lnk.sck_fall && fr == fuc_pkg::FR_SEND)
		begin
			io_oe <= quad_cmd_mode ? 4'hf : 4'h2;
			io_out <= quad_cmd_mode ? tx[7:4] : {2'b00, tx[7], 1'b0};
			tx <= quad_cmd_mode ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
		end
	end

	// ==========================================================
	// Command execution on select rise
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			arm <= 1'b0;
			req_init <= 1'b0;
			req_unlock <= 1'b0;
			req_sleep <= 1'b0;
			req_wake <= 1'b0;
			req_clear <= 1'b0;
			req_exit <= 1'b0;
		end
		else
		begin
			req_init <= 1'b0;
			req_unlock <= 1'b0;
			req_sleep <= 1'b0;
			req_wake <= 1'b0;
			req_clear <= 1'b0;
			req_exit <= 1'b0;
			if (lnk.cs_end)
			begin
				req_exit <= exit_clks == EXIT_CLKS && exit_ones;
				if (opc_seen)
				begin
					arm <= opc_ok && opc == `FUC_OPC_ARM && cnt == OPC_END;
					req_init <= opc_ok && opc == `FUC_OPC_INIT && cnt == OPC_END && arm;
					req_unlock <= opc_ok && opc == `FUC_OPC_UNLOCK && cnt == PASS_END;
					req_sleep <= opc_ok && opc == `FUC_OPC_SLEEP && cnt == OPC_END;
					req_wake <= opc_ok && opc == `FUC_OPC_WAKE && sleep_mode;
					req_clear <= opc_ok && opc == `FUC_OPC_FLAG_CLR && cnt == OPC_END;
				end
			end
		end
	end

	// ==========================================================
	// Operation sequencer
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			op <= fuc_pkg::OP_POWERUP;
			tmr_start <= 1'b1;
			tmr_load <= POWER_UP_CYC;
			fail <= 1'b0;
			por_ok <= 1'b0;
		end
		else
		begin
			tmr_start <= 1'b0;
			unique case (op)
				fuc_pkg::OP_POWERUP:
					if (por_abort)
						op <= fuc_pkg::OP_READY;
					else if (tmr_done)
					begin
						por_ok <= 1'b1;
						op <= fuc_pkg::OP_READY;
					end
				fuc_pkg::OP_READY, fuc_pkg::OP_FAIL:
					if (req_init)
					begin
						op <= fuc_pkg::OP_RESET;
						tmr_start <= 1'b1;
						tmr_load <= por_ok ? SW_INIT_CYC : POWER_UP_CYC;
						fail <= 1'b0;
					end
					else if (op == fuc_pkg::OP_FAIL && req_clear)
					begin
						op <= fuc_pkg::OP_READY;
						fail <= 1'b0;
					end
					else if (op == fuc_pkg::OP_READY && req_unlock)
					begin
						op <= fuc_pkg::OP_UNLOCK;
						tmr_start <= 1'b1;
						tmr_load <= UNLOCK_CYC;
					end
					else if (op == fuc_pkg::OP_READY && req_sleep)
					begin
						op <= fuc_pkg::OP_DOZE;
						tmr_start <= 1'b1;
						tmr_load <= ENTRY_CYC;
					end
				fuc_pkg::OP_UNLOCK:
					if (tmr_done)
					begin
						op <= pw_match ? fuc_pkg::OP_READY : fuc_pkg::OP_FAIL;
						fail <= !pw_match;
					end
				fuc_pkg::OP_RESET:
					if (tmr_done)
					begin
						por_ok <= 1'b1;
						op <= fuc_pkg::OP_READY;
					end
				fuc_pkg::OP_DOZE:
					if (tmr_done)
						op <= fuc_pkg::OP_SLEEP;
				fuc_pkg::OP_SLEEP:
					if (req_wake)
					begin
						op <= fuc_pkg::OP_WAKE;
						tmr_start <= 1'b1;
						tmr_load <= WAKE_CYC;
					end
				fuc_pkg::OP_WAKE:
					if (tmr_done)
						op <= fuc_pkg::OP_READY;
			endcase
		end
	end

	// ==========================================================
	// Protection bits kept across software reset
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			protection_freeze_bit <= nv_freeze_default;
			cfg_guard_bit <= nv_cfg_guard;
		end
		else
		begin
			if (unlock_hit)
				protection_freeze_bit <= 1'b1;
			if (cfg_guard_set)
				cfg_guard_bit <= 1'b1;
		end
	end

	// ==========================================================
	// Continuous read mode
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
			cont_read_mode <= 1'b0;
		else if (cont_read_enter && op == fuc_pkg::OP_READY)
			cont_read_mode <= 1'b1;
		else if (req_exit || op == fuc_pkg::OP_RESET)
			cont_read_mode <= 1'b0;
	end

	// ==========================================================
	// Status outputs
	always_ff @(posedge clk_sys)
	begin
		if (hard_rst)
		begin
			op_pending_flag <= 1'b0;
			prog_fail_flag <= 1'b0;
			sleep_mode <= 1'b0;
			vol_reload <= 1'b0;
			dev_ready <= 1'b0;
		end
		else
		begin
			op_pending_flag <= op == fuc_pkg::OP_UNLOCK || op == fuc_pkg::OP_FAIL;
			prog_fail_flag <= fail;
			sleep_mode <= op == fuc_pkg::OP_SLEEP;
			vol_reload <= op == fuc_pkg::OP_RESET;
			dev_ready <= op == fuc_pkg::OP_READY;
		end
	end

endmodule

//--- fuc_cmd_core_bench.sv
// Self-checking bench for the flash command block, driven through the host model.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ns
`include "fuc_consts.svh"
module fuc_cmd_core_bench;
	typedef struct packed {logic q; logic [63:0] pw; logic ok;} fuc_row_t;
	localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
	logic clk_sys = 1'b0, sys_rst = 1'b1, hw_rst_n = 1'b1, qm = 1'b0, go = 1'b0;
	logic array_busy = 1'b0, cr_enter = 1'b0, por_abort = 1'b0, done, cs_n, sck;
	logic [7:0] nbits = 8'h0, rx;
	logic [71:0] frame = 72'h0;
	logic [3:0] io_in, io_out, io_oe;
	logic op_pending_flag, prog_fail_flag, protection_freeze_bit, cfg_guard_bit;
	logic cont_read_mode, sleep_mode, vol_reload, dev_ready;
	int failures = 0, cmp_count = 0;
	fuc_row_t rows [3] = '{{1'b0, ~PW, 1'b0}, {1'b1, PW ^ 64'h1, 1'b0}, {1'b1, PW, 1'b1}};

	fuc_host_model fuc_host_model_i (.clk_sys, .go, .quad(qm), .nbits, .frame, .done, .rx,
		.cs_n, .sck, .io_in, .io_out);
	fuc_cmd_core #(.POWER_UP_CYC(16'h0032)) fuc_cmd_core_i (.clk_sys, .sys_rst, .cs_n, .sck,
		.io_in, .io_out, .io_oe, .hw_rst_n, .quad_cmd_mode(qm), .hidden_password(PW),
		.nv_freeze_default(1'b0), .nv_cfg_guard(1'b1), .cfg_guard_set(1'b0),
		.cont_read_enter(cr_enter), .array_busy, .por_abort, .op_pending_flag,
		.prog_fail_flag, .protection_freeze_bit, .cfg_guard_bit, .cont_read_mode, .sleep_mode,
		.vol_reload, .dev_ready);

	// ==========================================================
	// Tasks
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int n);
		int k;
		k = 0;
		while (s !== v && k < n)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (s !== v)
		begin
			chk(8'(s), 8'(v));
			results();
		end
	endtask
	task automatic xfer(input logic q, input logic [7:0] bits, input logic [7:0] op,
		input logic [63:0] tail = 64'h0);
		@(posedge clk_sys);
		qm <= q;
		nbits <= q ? bits >> 2 : bits;
		frame <= {op, tail};
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		wait_lvl(done, 1'b1, 2000);
	endtask
	function automatic logic [63:0] pwb(input logic [63:0] pw);
		for (int i = 0; i < 8; i++)
			pwb[63 - 8 * i -: 8] = pw[8 * i +: 8];
	endfunction

	// ==========================================================
	// Clock and main sequence
	initial
	begin
		forever
			#4 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		chk(8'({protection_freeze_bit, cfg_guard_bit}), 8'h1);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		wait_lvl(dev_ready, 1'b1, 200);
		xfer(1'b0, 8'd64, 8'hea, pwb(PW));
		repeat (20) @(posedge clk_sys);
		chk(8'(op_pending_flag), 8'h0);
		$display("-- reset and short unlock done");
		foreach (rows[i])
		begin
			xfer(rows[i].q, 8'd72, 8'hea, pwb(rows[i].pw));
			xfer(rows[i].q, 8'd16, 8'h05);
			chk(8'(rx[0]), 8'h1);
			repeat (1000) @(posedge clk_sys);
			chk(8'({prog_fail_flag, op_pending_flag, protection_freeze_bit}),
				rows[i].ok ? 8'h1 : 8'h6);
			if (!rows[i].ok)
			begin
				xfer(1'b0, 8'd8, 8'h30);
				repeat (10) @(posedge clk_sys);
				chk(8'({prog_fail_flag, op_pending_flag}), 8'h0);
			end
			$display("-- unlock row %0d done", i);
		end
		xfer(1'b0, 8'd72, 8'hea, pwb(~PW));
		repeat (1010) @(posedge clk_sys);
		xfer(1'b0, 8'd8, 8'hff);
		xfer(1'b0, 8'd8, 8'h66);
		xfer(1'b0, 8'd16, 8'h05);
		xfer(1'b0, 8'd8, 8'h99);
		repeat (10) @(posedge clk_sys);
		chk(8'({vol_reload, prog_fail_flag}), 8'h1);
		xfer(1'b0, 8'd8, 8'h66);
		xfer(1'b0, 8'd8, 8'h99);
		repeat (10) @(posedge clk_sys);
		chk(8'({vol_reload, prog_fail_flag, op_pending_flag, protection_freeze_bit,
			cfg_guard_bit}), 8'h13);
		wait_lvl(dev_ready, 1'b1, 4000);
		$display("-- software reset done");
		cr_enter <= 1'b1;
		@(posedge clk_sys);
		cr_enter <= 1'b0;
		xfer(1'b0, 8'd8, 8'h05);
		chk(8'(cont_read_mode), 8'h1);
		xfer(1'b0, 8'd8, 8'hff);
		repeat (10) @(posedge clk_sys);
		chk(8'(cont_read_mode), 8'h0);
		$display("-- continuous read exit done");
		xfer(1'b0, 8'd8, 8'hb9);
		wait_lvl(sleep_mode, 1'b1, 500);
		array_busy <= 1'b1;
		xfer(1'b0, 8'd8, 8'hab);
		xfer(1'b0, 8'd16, 8'h05);
		chk(8'(sleep_mode), 8'h1);
		array_busy <= 1'b0;
		xfer(1'b0, 8'd8, 8'hab);
		repeat (10) @(posedge clk_sys);
		chk(8'({sleep_mode, dev_ready}), 8'h0);
		wait_lvl(dev_ready, 1'b1, 4000);
		$display("-- sleep and wake done");
		xfer(1'b0, 8'd40, 8'hab);
		chk(rx, `FUC_DEV_ID);
		xfer(1'b1, 8'd40, 8'hab);
		chk(rx, `FUC_DEV_ID);
		repeat (20) @(posedge clk_sys);
		$display("-- ident read done");
		xfer(1'b0, 8'd8, 8'hb9);
		wait_lvl(sleep_mode, 1'b1, 500);
		hw_rst_n <= 1'b0;
		por_abort <= 1'b1;
		repeat (4) @(posedge clk_sys);
		hw_rst_n <= 1'b1;
		wait_lvl(dev_ready, 1'b1, 200);
		chk(8'({sleep_mode, protection_freeze_bit}), 8'h0);
		$display("-- hardware reset from sleep done");
		por_abort <= 1'b0;
		xfer(1'b0, 8'd8, 8'h66);
		xfer(1'b0, 8'd8, 8'h99);
		repeat (10) @(posedge clk_sys);
		chk(8'(vol_reload), 8'h1);
		wait_lvl(dev_ready, 1'b1, 100);
		$display("-- reset after failed power-up done");
		results();
	end
endmodule

//--- fuc_cmd_core_props.sv
// Checker for the flash command block, watching only the top module's ports.
// Assumes one clk_sys domain with synchronous reset; attached by the bind below.
`timescale 1ns/1ns
module fuc_cmd_core_props
(
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pins and defaults
	input wire logic cs_n,
	input wire logic hw_rst_n,
	input wire logic quad_cmd_mode,
	input wire logic nv_freeze_default,
	input wire logic nv_cfg_guard,
	input wire logic [3:0] io_oe,
	// Status
	input wire logic op_pending_flag,
	input wire logic prog_fail_flag,
	input wire logic protection_freeze_bit,
	input wire logic cfg_guard_bit,
	input wire logic cont_read_mode,
	input wire logic sleep_mode,
	input wire logic vol_reload,
	input wire logic dev_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Idle time: select high and no hardware reset, saturating
	logic [3:0] quiet;
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || !cs_n || !hw_rst_n)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	// ==========================================================
	// Properties
	property p_reset_vals;
		$fell(sys_rst) |-> protection_freeze_bit == $past(nv_freeze_default)
			&& cfg_guard_bit == $past(nv_cfg_guard);
	endproperty
	property p_fail_pend;
		prog_fail_flag |-> op_pending_flag;
	endproperty
	property p_fail_hold;
		prog_fail_flag && quiet == 4'hf |=> prog_fail_flag;
	endproperty
	property p_pend_start;
		$rose(op_pending_flag) |-> $past(cs_n, 3) && cs_n ##1 op_pending_flag [*8];
	endproperty
	property p_sleep_mute;
		sleep_mode |-> io_oe == 4'h0 && !dev_ready && !op_pending_flag;
	endproperty
	property p_wake_wait;
		$fell(sleep_mode) |-> !dev_ready [*8];
	endproperty
	property p_reload;
		$rose(vol_reload) |-> (vol_reload && !dev_ready) [*8];
	endproperty
	property p_keep_bits;
		vol_reload |-> protection_freeze_bit == $past(protection_freeze_bit, 3)
			&& cfg_guard_bit == $past(cfg_guard_bit, 3);
	endproperty
	property p_oe_width;
		io_oe != 4'h0 |-> io_oe == (quad_cmd_mode ? 4'hf : 4'h2);
	endproperty
	property p_cont_hold;
		cont_read_mode && quiet == 4'hf |=> cont_read_mode;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("freeze or guard bit not at default after reset");
	a_fail_pend: assert property (p_fail_pend)
		else $error("failure flag without pending flag");
	a_fail_hold: assert property (p_fail_hold)
		else $error("failure flag cleared with no command");
	a_pend_start: assert property (p_pend_start)
		else $error("pending flag rose early or fell too soon");
	a_sleep_mute: assert property (p_sleep_mute)
		else $error("activity while asleep");
	a_wake_wait: assert property (p_wake_wait)
		else $error("ready too soon after wake");
	a_reload: assert property (p_reload)
		else $error("software reset too short");
	a_keep_bits: assert property (p_keep_bits)
		else $error("freeze or guard bit changed by software reset");
	a_oe_width: assert property (p_oe_width)
		else $error("wrong data lines driven");
	a_cont_hold: assert property (p_cont_hold)
		else $error("continuous read left with no frame");
	c_fail: cover property ($rose(prog_fail_flag));
	c_sleep: cover property ($rose(sleep_mode));
	c_reload: cover property ($rose(vol_reload));
endmodule

bind fuc_cmd_core fuc_cmd_core_props fuc_cmd_core_props_i (.clk_sys, .sys_rst, .cs_n, .hw_rst_n,
	.quad_cmd_mode, .nv_freeze_default, .nv_cfg_guard, .io_oe, .op_pending_flag, .prog_fail_flag,
	.protection_freeze_bit, .cfg_guard_bit, .cont_read_mode, .sleep_mode, .vol_reload, .dev_ready);

//--- fuc_consts.svh
// Constants for the flash command block: opcodes, field positions, times.
// Assumes a 125 MHz system clock; times are in ns and turned into cycles here.
`ifndef FUC_CONSTS_SVH
`define FUC_CONSTS_SVH

// ==========================================================
// Clock and time conversion
`define FUC_CLK_MHZ 125
`define FUC_CYC_UP(ns) ((((ns) * `FUC_CLK_MHZ) + 999) / 1000)
`define FUC_CYC_DN(ns) (((ns) * `FUC_CLK_MHZ) / 1000)

// ==========================================================
// Self-timed durations
`define FUC_SW_INIT_NS 30000
`define FUC_POWER_UP_NS 300000
`define FUC_SLEEP_ENTRY_NS 3000
`define FUC_WAKE_NS 30000
`define FUC_UNLOCK_NS 8000
`define FUC_TMR_W 16

// ==========================================================
// Opcodes
`define FUC_OPC_UNLOCK 8'hea
`define FUC_OPC_ARM 8'h66
`define FUC_OPC_INIT 8'h99
`define FUC_OPC_SLEEP 8'hb9
`define FUC_OPC_WAKE 8'hab
`define FUC_OPC_FLAG_CLR 8'h30
`define FUC_OPC_STAT_RD 8'h05

// ==========================================================
// Frame lengths in bits
`define FUC_OPC_BITS 8
`define FUC_PW_BITS 64
`define FUC_DUMMY_BITS 24
`define FUC_EXIT_CLKS 8

// ==========================================================
// Status byte fields and reset values
`define FUC_STAT_PEND 0
`define FUC_STAT_FAIL 6
`define FUC_SYNC_RST 7'h60
`define FUC_DEV_ID 8'h5a

`endif

//--- fuc_host_model.sv
// Host model: sends one SPI mode 0 frame per go pulse and collects returned bits.
// Assumes go is a one-cycle pulse on clk_sys; nbits counts serial clocks.
`timescale 1ns/1ns
module fuc_host_model
(
	// System
	input wire logic clk_sys,
	// Frame request
	input wire logic go,
	input wire logic quad,
	input wire logic [7:0] nbits,
	input wire logic [71:0] frame,
	output logic done,
	output logic [7:0] rx,
	// Pins
	output logic cs_n,
	output logic sck,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out
);
	logic [71:0] sh;
	initial
	begin
		{cs_n, sck, io_in, done, rx} = {1'b1, 1'b0, 4'h0, 1'b0, 8'h0};
		forever
		begin
			@(posedge clk_sys);
			done <= 1'b0;
			// Released lines toggle so no stale level passes for data
			if (!go)
				io_in <= ~io_in;
			else
			begin
				sh = frame;
				cs_n <= 1'b0;
				repeat (nbits)
				begin
					io_in <= quad ? sh[71:68] : {~io_in[3:1], sh[71]};
					sh = quad ? sh << 4 : sh << 1;
					repeat (10) @(posedge clk_sys);
					sck <= 1'b1;
					rx <= quad ? {rx[3:0], io_out} : {rx[6:0], io_out[1]};
					repeat (10) @(posedge clk_sys);
					sck <= 1'b0;
				end
				repeat (4) @(posedge clk_sys);
				cs_n <= 1'b1;
				repeat (4) @(posedge clk_sys);
				done <= 1'b1;
			end
		end
	end
endmodule

//--- fuc_link_if.sv
// Synchronised link events passed from the pin sampler to the command core.
// Assumes all members are driven in the clk_sys domain.
`timescale 1ns/1ns
interface fuc_link_if;
	logic sck_rise;
	logic sck_fall;
	logic cs_active;
	logic cs_start;
	logic cs_end;
	logic [3:0] io;
	logic hw_rst;

	modport src
	(
		output sck_rise, sck_fall, cs_active, cs_start, cs_end, io, hw_rst
	);
	modport dst
	(
		input sck_rise, sck_fall, cs_active, cs_start, cs_end, io, hw_rst
	);
endinterface

//--- fuc_link_sync.sv
// Pin sampler: two-flop synchronisers and edge detection for the SPI pins.
// Assumes the serial clock is far slower than clk_sys.
`timescale 1ns/1ns
`include "fuc_consts.svh"
module fuc_link_sync
(
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	input wire logic hw_rst_n,
	// Events
	fuc_link_if.src lnk
);

	// ==========================================================
	// Synchroniser chain: bit 6 reset pin, 5 select, 4 clock, 3..0 data
	logic [6:0] meta;
	logic [6:0] sync;
	logic [6:0] prev;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			meta <= `FUC_SYNC_RST;
			sync <= `FUC_SYNC_RST;
			prev <= `FUC_SYNC_RST;
		end
		else
		begin
			meta <= {hw_rst_n, cs_n, sck, io_in};
			sync <= meta;
			prev <= sync;
		end
	end

	// ==========================================================
	// Events seen only from the second stage onward
	assign lnk.cs_active = ~sync[5];
	assign lnk.cs_start = ~sync[5] & prev[5];
	assign lnk.cs_end = sync[5] & ~prev[5];
	assign lnk.sck_rise = sync[4] & ~prev[4] & ~sync[5];
	assign lnk.sck_fall = ~sync[4] & prev[4] & ~sync[5];
	assign lnk.io = sync[3:0];
	assign lnk.hw_rst = ~sync[6];

endmodule

//--- fuc_pkg.sv
// Types shared by the flash command block.
// Assumes nothing beyond the constants header.
package fuc_pkg;

	// ==========================================================
	// Serial frame states
	typedef enum {FR_IDLE, FR_OPCODE, FR_PASS, FR_DUMMY, FR_SEND, FR_SKIP} fuc_frame_t;

	// ==========================================================
	// Operation states
	typedef enum {OP_POWERUP, OP_READY, OP_UNLOCK, OP_FAIL, OP_RESET, OP_DOZE, OP_SLEEP,
		OP_WAKE} fuc_op_t;

endpackage

//--- fuc_timer.sv
// Down counter for self-timed operations; done pulses once per start.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ns
`include "fuc_consts.svh"
module fuc_timer
(
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic [`FUC_TMR_W-1:0] load,
	output logic busy,
	output logic done
);

	logic [`FUC_TMR_W-1:0] cnt;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt <= load;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				if (cnt <= `FUC_TMR_W'(1))
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else
					cnt <= cnt - `FUC_TMR_W'(1);
			end
		end
	end

endmodule
